// >>> common/rtp_pkg.sv
// constants and carriers of the real-time trace port
// assumes one processor clock and an async active-high reset
package rtp_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int RTP_EXEC_W  = 2;
    localparam int RTP_INFO_W  = 2;
    localparam int RTP_STAT_W  = 4;
    localparam int RTP_EVENT_W = 11;

    // ****************************************************************
    // event kind bit positions
    // ****************************************************************
    localparam int RTP_EV_IAM1   = 0;
    localparam int RTP_EV_IAM2   = 1;
    localparam int RTP_EV_IAM3   = 2;
    localparam int RTP_EV_IAM4   = 3;
    localparam int RTP_EV_DAM1_R = 4;
    localparam int RTP_EV_DAM1_W = 5;
    localparam int RTP_EV_DAM2_R = 6;
    localparam int RTP_EV_DAM2_W = 7;
    localparam int RTP_EV_TRAP   = 8;
    localparam int RTP_EV_EXCEPT = 9;
    localparam int RTP_EV_UNCOND = 10;

    // ****************************************************************
    // reset values and counts
    // ****************************************************************
    localparam logic [RTP_EVENT_W-1:0] RTP_KIND_RST = 11'h000;
    localparam logic [RTP_EXEC_W-1:0]  RTP_EXEC_RST = 2'h0;
    localparam logic [RTP_STAT_W-1:0]  RTP_STAT_RST = 4'h0;
    localparam int                     RTP_PAIR_CLKS = 2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic {RTP_PH_EVEN, RTP_PH_ODD} rtp_phase_e;

    // one processor cycle of trace sample
    typedef struct packed {
        logic [RTP_EXEC_W-1:0] exec;
        logic [RTP_INFO_W-1:0] info;
        logic [RTP_INFO_W-1:0] trig_info;
    } rtp_sample_s;

    // debug event sources, one bit per event kind
    typedef struct packed {
        logic       unconditional_debug_event;
        logic       exception_debug_event;
        logic       trap_debug_event;
        logic [1:0] data_addr_match_2;   // [1] write, [0] read
        logic [1:0] data_addr_match_1;   // [1] write, [0] read
        logic       instr_addr_match_4;
        logic       instr_addr_match_3;
        logic       instr_addr_match_2;
        logic       instr_addr_match_1;
    } rtp_events_s;

endpackage : rtp_pkg

// >>> rtl/rtp_pair_capture.sv
// pairs two processor-cycle samples into one trace-cycle broadcast
// assumes the phase and capture enables come from the port top
module rtp_pair_capture
    import rtp_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  take_even,
    input  wire logic                  take_odd,
    input  wire rtp_sample_s           sample,
    input  wire logic                  extra_req,
    output logic [RTP_EXEC_W-1:0]      even_exec_status,
    output logic [RTP_EXEC_W-1:0]      odd_exec_status,
    output logic [RTP_STAT_W-1:0]      trace_status_bus
);

    // ****************************************************************
    // earlier half and broadcast registers
    // ****************************************************************
    rtp_sample_s               early_q;
    logic [RTP_STAT_W-1:0]     stat_d;
    logic [RTP_STAT_W-1:0]     norm_stat;
    logic [RTP_STAT_W-1:0]     extra_stat;

    assign norm_stat  = {early_q.info, sample.info};
    assign extra_stat = {early_q.trig_info, sample.trig_info};
    // extra status replaces plain status for the triggered pair
    assign stat_d     = extra_req ? extra_stat : norm_stat;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            early_q <= '0;
        end
        else if (take_even)
        begin
            early_q <= sample;
        end
    end

    // outputs hold between strobes so slow tools see stable data
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            even_exec_status <= RTP_EXEC_RST;
            odd_exec_status  <= RTP_EXEC_RST;
            trace_status_bus <= RTP_STAT_RST;
        end
        else if (take_odd)
        begin
            even_exec_status <= early_q.exec;
            odd_exec_status  <= sample.exec;
            trace_status_bus <= stat_d;
        end
    end

endmodule : rtp_pair_capture

// >>> rtl/rtp_trace_port.sv
// real-time trace port: trigger generation and paired status broadcast
// assumes core status inputs are valid every processor clock and the
// fabric returns its qualified trigger on the same clock domain
module rtp_trace_port
    import rtp_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire rtp_events_s             debug_events,
    input  wire logic                    internal_debug_mode,
    input  wire logic                    external_debug_mode,
    input  wire rtp_sample_s             core_sample,
    input  wire logic                    trigger_return_in,
    input  wire logic                    trace_disable_in,
    output logic                         trigger_out,
    output logic [RTP_EVENT_W-1:0]       trigger_event_kind,
    output logic                         trace_cycle_strobe,
    output logic [RTP_EXEC_W-1:0]        even_exec_status,
    output logic [RTP_EXEC_W-1:0]        odd_exec_status,
    output logic [RTP_STAT_W-1:0]        trace_status_bus
);

    // ****************************************************************
    // trigger generation
    // ****************************************************************
    logic [RTP_EVENT_W-1:0] event_vec;
    logic                   modes_off;
    logic [RTP_EVENT_W-1:0] kind_d;
    logic                   trig_d;

    // packed struct order puts comparator 1 at bit 0
    assign event_vec = debug_events;
    assign modes_off = !internal_debug_mode && !external_debug_mode;
    assign kind_d    = modes_off ? event_vec : RTP_KIND_RST;
    assign trig_d    = |kind_d;

    // kind and trigger share one register stage so they stay aligned
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            trigger_out        <= 1'b0;
            trigger_event_kind <= RTP_KIND_RST;
        end
        else
        begin
            trigger_out        <= trig_d;
            trigger_event_kind <= kind_d;
        end
    end

    // ****************************************************************
    // pair phase and disable handling
    // ****************************************************************
    rtp_phase_e phase_q;
    rtp_phase_e phase_d;
    logic       take_even;
    logic       take_odd;
    logic       trig_seen_q;
    logic       extra_req;

    // disable is only honoured at a pair boundary, so a half-collected
    // pair always completes and is broadcast before tracing stops
    assign take_even = (phase_q == RTP_PH_EVEN) && !trace_disable_in;
    assign take_odd  = (phase_q == RTP_PH_ODD);
    assign extra_req = trig_seen_q || trigger_return_in;

    always_comb
    begin
        phase_d = phase_q;
        unique case (phase_q)
            RTP_PH_EVEN:
                phase_d = take_even ? RTP_PH_ODD : RTP_PH_EVEN;
            RTP_PH_ODD:
                phase_d = RTP_PH_EVEN;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            phase_q            <= RTP_PH_EVEN;
            trace_cycle_strobe <= 1'b0;
        end
        else
        begin
            phase_q            <= phase_d;
            trace_cycle_strobe <= take_odd;
        end
    end

    // a trigger returned during either clock of the pair marks that pair
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            trig_seen_q <= 1'b0;
        end
        else if (take_odd || !take_even && phase_q == RTP_PH_EVEN)
        begin
            trig_seen_q <= 1'b0;
        end
        else if (take_even && trigger_return_in)
        begin
            trig_seen_q <= 1'b1;
        end
    end

    // ****************************************************************
    // pairing of samples
    // ****************************************************************
    rtp_pair_capture u_pair (
        .sys_clk          (sys_clk),
        .reset            (reset),
        .take_even        (take_even),
        .take_odd         (take_odd),
        .sample           (core_sample),
        .extra_req        (extra_req),
        .even_exec_status (even_exec_status),
        .odd_exec_status  (odd_exec_status),
        .trace_status_bus (trace_status_bus)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_free_event;
        modes_off && (|event_vec);
    endsequence

    sequence s_pair_taken;
        take_even ##1 take_odd;
    endsequence

    property p_trig_free;
        @(posedge sys_clk) disable iff (reset)
        s_free_event |=> trigger_out;
    endproperty
    a_trig_free: assert property (p_trig_free)
        else $error("trigger missing for free event");

    property p_trig_blocked;
        @(posedge sys_clk) disable iff (reset)
        (internal_debug_mode || external_debug_mode) |=> !trigger_out;
    endproperty
    a_trig_blocked: assert property (p_trig_blocked)
        else $error("trigger raised in debug mode");

    property p_kind_with_trig;
        @(posedge sys_clk) disable iff (reset)
        (|trigger_event_kind) == trigger_out;
    endproperty
    a_kind_with_trig: assert property (p_kind_with_trig)
        else $error("event kind and trigger disagree");

    property p_kind_iam1;
        @(posedge sys_clk) disable iff (reset)
        s_free_event |=> trigger_event_kind[RTP_EV_IAM1]
            == $past(debug_events.instr_addr_match_1);
    endproperty
    a_kind_iam1: assert property (p_kind_iam1)
        else $error("comparator 1 kind bit wrong");

    property p_kind_dam2w;
        @(posedge sys_clk) disable iff (reset)
        s_free_event |=> trigger_event_kind[RTP_EV_DAM2_W]
            == $past(debug_events.data_addr_match_2[1]);
    endproperty
    a_kind_dam2w: assert property (p_kind_dam2w)
        else $error("data comparator 2 write bit wrong");

    property p_kind_uncond;
        @(posedge sys_clk) disable iff (reset)
        s_free_event |=> trigger_event_kind[RTP_EV_UNCOND]
            == $past(debug_events.unconditional_debug_event);
    endproperty
    a_kind_uncond: assert property (p_kind_uncond)
        else $error("unconditional kind bit wrong");

    property p_strobe_single;
        @(posedge sys_clk) disable iff (reset)
        trace_cycle_strobe |=> !trace_cycle_strobe;
    endproperty
    a_strobe_single: assert property (p_strobe_single)
        else $error("strobe longer than one clock");

    property p_strobe_period;
        @(posedge sys_clk) disable iff (reset)
        (!trace_disable_in)[*3] |-> ##1
            (trace_cycle_strobe != $past(trace_cycle_strobe));
    endproperty
    a_strobe_period: assert property (p_strobe_period)
        else $error("strobe not every second clock");

    property p_even_exec;
        @(posedge sys_clk) disable iff (reset)
        s_pair_taken |=> even_exec_status == $past(core_sample.exec, 2);
    endproperty
    a_even_exec: assert property (p_even_exec)
        else $error("even status not from earlier cycle");

    property p_odd_exec;
        @(posedge sys_clk) disable iff (reset)
        s_pair_taken |=> odd_exec_status == $past(core_sample.exec);
    endproperty
    a_odd_exec: assert property (p_odd_exec)
        else $error("odd status not from later cycle");

    property p_status_hold;
        @(posedge sys_clk) disable iff (reset)
        !trace_cycle_strobe |-> $stable(trace_status_bus);
    endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("trace status changed outside trace cycle");

    property p_extra_info;
        @(posedge sys_clk) disable iff (reset)
        (take_even && trigger_return_in) ##1 take_odd |=>
            trace_status_bus[RTP_INFO_W-1:0]
                == $past(core_sample.trig_info);
    endproperty
    a_extra_info: assert property (p_extra_info)
        else $error("extra trace status missing");

    property p_no_extra;
        @(posedge sys_clk) disable iff (reset)
        (take_even && !trigger_return_in)
            ##1 (take_odd && !trigger_return_in) |=>
            trace_status_bus[RTP_INFO_W-1:0] == $past(core_sample.info);
    endproperty
    a_no_extra: assert property (p_no_extra)
        else $error("extra trace status without trigger");

    property p_disable_stops;
        @(posedge sys_clk) disable iff (reset)
        trace_disable_in[*2] |=> !trace_cycle_strobe;
    endproperty
    a_disable_stops: assert property (p_disable_stops)
        else $error("broadcast while disabled");

    property p_drain;
        @(posedge sys_clk) disable iff (reset)
        (phase_q == RTP_PH_ODD) |=> trace_cycle_strobe;
    endproperty
    a_drain: assert property (p_drain)
        else $error("collected half pair not broadcast");

endmodule : rtp_trace_port

// >>> sim/rtp_fabric_model.sv
// fabric trigger qualifier and trace tool capture counter
// assumes the port's trigger outputs are registered on sys_clk
module rtp_fabric_model
    import rtp_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    input  wire logic                   trigger_out,
    input  wire logic [RTP_EVENT_W-1:0] trigger_event_kind,
    input  wire logic [RTP_EVENT_W-1:0] qual_mask,
    input  wire logic                   trace_cycle_strobe,
    output logic                        trigger_return_in,
    output logic [7:0]                  capture_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // combinational so the qualified trigger lands in the same trace cycle
    logic qual_hit;

    assign qual_hit          = |(trigger_event_kind & qual_mask);
    assign trigger_return_in = trigger_out & qual_hit;
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            capture_count <= 8'h00;
        else if (trace_cycle_strobe && trigger_return_in)
            capture_count <= capture_count + 8'h01;
    end
endmodule : rtp_fabric_model

// >>> sim/rtp_trace_port_tb_top.sv
// self-checking bench of the trace port with a reference pair model
// assumes registered outputs one clock after their sampling edge
module rtp_trace_port_tb_top
    import rtp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic                   sys_clk;
    logic                   reset;
    rtp_events_s            debug_events;
    logic                   internal_debug_mode;
    logic                   external_debug_mode;
    rtp_sample_s            core_sample;
    logic                   trace_disable_in;
    logic [RTP_EVENT_W-1:0] qual_mask;
    logic                   trigger_return_in;
    logic                   trigger_out;
    logic [RTP_EVENT_W-1:0] trigger_event_kind;
    logic                   trace_cycle_strobe;
    logic [RTP_EXEC_W-1:0]  even_exec_status;
    logic [RTP_EXEC_W-1:0]  odd_exec_status;
    logic [RTP_STAT_W-1:0]  trace_status_bus;
    logic [RTP_EVENT_W-1:0] exp_kind;
    rtp_sample_s            exp_first;
    logic                   exp_odd_ph;
    logic                   exp_seen;
    logic [8:0]             exp_trace;
    logic [7:0]             capture_count;
    logic [7:0]             exp_capture;
    logic [31:0]            r;
    int                     bad_count;
    int                     n_checks;
    int                     cycles;
    int                     seed;

    rtp_trace_port rtp_trace_port_inst (
        .sys_clk(sys_clk), .reset(reset), .debug_events(debug_events),
        .internal_debug_mode(internal_debug_mode),
        .external_debug_mode(external_debug_mode),
        .core_sample(core_sample), .trigger_return_in(trigger_return_in),
        .trace_disable_in(trace_disable_in), .trigger_out(trigger_out),
        .trigger_event_kind(trigger_event_kind),
        .trace_cycle_strobe(trace_cycle_strobe),
        .even_exec_status(even_exec_status),
        .odd_exec_status(odd_exec_status),
        .trace_status_bus(trace_status_bus));

    rtp_fabric_model rtp_fabric_model_inst (
        .sys_clk(sys_clk), .reset(reset), .trigger_out(trigger_out),
        .trigger_event_kind(trigger_event_kind), .qual_mask(qual_mask),
        .trace_cycle_strobe(trace_cycle_strobe),
        .trigger_return_in(trigger_return_in),
        .capture_count(capture_count));

    // ****************************************************************
    // expectation
    // ****************************************************************
    function automatic logic [RTP_EVENT_W-1:0] kind_f(
        input logic [RTP_EVENT_W-1:0] ev, input logic im, input logic em);
        return (im | em) ? '0 : ev;
    endfunction : kind_f

    // strobe, even exec, odd exec, then status halves earlier first
    function automatic logic [8:0] trace_f(
        input rtp_sample_s a, input rtp_sample_s b, input logic trig);
        return {1'b1, a.exec, b.exec,
                trig ? {a.trig_info, b.trig_info} : {a.info, b.info}};
    endfunction : trace_f

    // reset is async in the port, so the model resets the same way
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            exp_kind <= RTP_KIND_RST;
            exp_odd_ph <= 1'b0;
            exp_seen <= 1'b0;
            exp_first <= '0;
            exp_trace <= '0;
            exp_capture <= 8'h00;
        end
        else
        begin
            exp_kind <= kind_f(debug_events, internal_debug_mode,
                               external_debug_mode);
            // tool captures when a returned trigger is present in the clock of the broadcast strobe
            if (exp_trace[8] && trigger_return_in)
                exp_capture <= exp_capture + 8'h01;
            exp_trace[8] <= 1'b0;
            if (exp_odd_ph)
            begin
                exp_trace <= trace_f(exp_first, core_sample,
                                     exp_seen | trigger_return_in);
                exp_odd_ph <= 1'b0;
            end
            else if (!trace_disable_in)
            begin
                exp_first <= core_sample;
                exp_seen <= trigger_return_in;
                exp_odd_ph <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // compare and report
    // ****************************************************************
    task automatic cmp_trig();
        n_checks++;
        if (trigger_out !== (|exp_kind) || trigger_event_kind !== exp_kind)
        begin
            bad_count++;
            $display("FAIL %0t trigger %b kind %h want %h", $time,
                     trigger_out, trigger_event_kind, exp_kind);
        end
    endtask : cmp_trig

    task automatic cmp_trace();
        n_checks++;
        if ({trace_cycle_strobe, even_exec_status, odd_exec_status,
             trace_status_bus} !== exp_trace)
        begin
            bad_count++;
            $display("FAIL %0t trace outputs differ, want %h", $time,
                     exp_trace);
        end
    endtask : cmp_trace

    task automatic cmp_capture();
        n_checks++;
        if (capture_count !== exp_capture)
        begin
            bad_count++;
            $display("FAIL %0t capture count %0d want %0d", $time,
                     capture_count, exp_capture);
        end
    endtask : cmp_capture

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    always @(negedge sys_clk)
    begin
        if (!reset)
        begin
            cmp_trig();
            cmp_trace();
            cmp_capture();
        end
    end

    // ****************************************************************
    // clock, timeout and stimulus
    // ****************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // run needs about 1600 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles >= 4000)
        begin
            bad_count++;
            $display("FAIL %0t timeout", $time);
            stop_test();
        end
    end

    task automatic drive(input logic [RTP_EVENT_W-1:0] ev, input logic im,
                         input logic em, input logic dis);
        @(negedge sys_clk);
        debug_events = ev;
        internal_debug_mode = im;
        external_debug_mode = em;
        trace_disable_in = dis;
        core_sample = 6'($random(seed));
    endtask : drive

    initial
    begin
        seed = 89655;
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        reset = 1'b1;
        debug_events = '0;
        internal_debug_mode = 1'b0;
        external_debug_mode = 1'b0;
        core_sample = '0;
        trace_disable_in = 1'b0;
        qual_mask = '1;
        repeat (8) @(negedge sys_clk);
        reset = 1'b0;
        // each event alone, then blocked by every mode combination
        for (int i = 0; i < RTP_EVENT_W; i++)
        begin
            for (int m = 0; m < 4; m++)
                drive(11'h001 << i, m[0], m[1], 1'b0);
        end
        // only trap qualifies; disable flips at both pair phases
        qual_mask = 11'h100;
        for (int i = 0; i < 9; i++)
            drive(11'h100, 1'b0, 1'b0, i[0]);
        repeat (6) drive('0, 1'b0, 1'b0, 1'b1);
        repeat (1500)
        begin
            r = $random(seed);
            drive(r[26:16] & {RTP_EVENT_W{r[0]}}, r[1] & r[2], r[3] & r[4],
                  r[5] & r[6] & r[7]);
            if (r[31:29] == 3'h0)
                qual_mask = r[10:0] | r[21:11];
        end
        // second reset in mid-run, then traffic again
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        repeat (20) drive(11'h7ff, 1'b0, 1'b0, 1'b0);
        stop_test();
    end
endmodule : rtp_trace_port_tb_top
